//--- rtl/qr_flyback_defines.svh
// Timing counts, thresholds and reset values of the flyback sequencer
`ifndef QR_FLYBACK_DEFINES_SVH
`define QR_FLYBACK_DEFINES_SVH
`define QF_CLK_NS 100
`define QF_CYC_PER_MS (1000000 / `QF_CLK_NS)
`define QF_LEB_NS 300
`define QF_LEB_CYC ((`QF_LEB_NS + `QF_CLK_NS - 1) / `QF_CLK_NS)
`define QF_TON_US 15
`define QF_TON_CYC ((`QF_TON_US * 1000) / `QF_CLK_NS)
`define QF_PER_US 40
`define QF_PER_CYC ((`QF_PER_US * 1000) / `QF_CLK_NS)
`define QF_SHORT_NS 420
`define QF_SHORT_CYC ((`QF_SHORT_NS + `QF_CLK_NS - 1) / `QF_CLK_NS)
`define QF_BO_MS 32
`define QF_BO_CYC (`QF_BO_MS * `QF_CYC_PER_MS)
`define QF_RST_MS 16
`define QF_RST_CYC (`QF_RST_MS * `QF_CYC_PER_MS)
`define QF_FLT_MS 2000
`define QF_FLT_CYC (`QF_FLT_MS * `QF_CYC_PER_MS)
`define QF_BIN_GOOD 3
`define QF_BIN_BAD 6
`define QF_SS_STEP 8
`define QF_LVL_MIN 4'h1
`define QF_LVL_MAX 4'hf
`endif

//--- rtl/qr_flyback_pkg.sv
// Types shared by the flyback sequencer
package qr_flyback_pkg;
    typedef enum logic [2:0] {
        S_OFF, S_QUAL, S_SOFT, S_RUN, S_RSTDLY, S_FAULT
    } state_t;
    typedef struct packed {
        logic vcc_start;
        logic vcc_low;
        logic bin_ok;
        logic bo_low;
        logic demag;
        logic cs_peak;
        logic cs_short;
        logic overload;
    } cmp_t;
    typedef logic [24:0] long_t;
    typedef struct packed {
        state_t st;
        cmp_t sy1;
        cmp_t sy2;
        logic dm_prev;
        logic gate;
        logic hv;
        logic run;
        logic ss;
        logic flt;
        logic [7:0] ontmr;
        logic [8:0] pertmr;
        logic [1:0] good;
        logic [2:0] bad;
        logic [2:0] shcnt;
        logic [3:0] sscnt;
        logic [3:0] lvl;
        long_t bo;
        long_t dly;
    } core_t;
endpackage : qr_flyback_pkg

//--- rtl/qr_flyback_pwm_sequencer.sv
// Start-up, brown-in/out and cycle timing core of a QR flyback controller
// Operation
// - High-voltage charger off once start-up reached
// - Run above turn-on, stop below turn-off
// - Three good brown-in cycles start soft-start
// - Six bad cycles: stop, 16 ms, restart
// - Restart re-runs qualification at start-up threshold
// - Soft-start follows successful qualification at once
// - Input low 32 ms stops switching
// - Brown-out: 16 ms, recharge, requalify
// - Demagnetization edge turns switch on
// - Peak current turns switch off
// - Blanking of 300 ns after turn-on
// - Current sense ignored while blanking
// - Switch forced off after 15 us
// - Period never exceeds 40 us
// - Protection trip holds off for 2000 ms
// - Short qualified over 420 ns
`timescale 1ns/1ns
`include "qr_flyback_defines.svh"
module qr_flyback_pwm_sequencer
    import qr_flyback_pkg::*;
#(
    parameter int unsigned BO_CYC = `QF_BO_CYC,   // Brown-out persistence
    parameter int unsigned RST_CYC = `QF_RST_CYC, // Reset delay
    parameter int unsigned FLT_CYC = `QF_FLT_CYC  // Protection hold-off
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic I_VCC_ABOVE_START, // Supply above start-up threshold
    input wire logic I_VCC_BELOW_RESET, // Supply below turn-off level
    input wire logic I_BROWN_IN_OK,     // Input above brown-in level
    input wire logic I_BROWN_OUT_LOW,   // Input below brown-out level
    input wire logic I_DEMAG,           // Aux sense below demag threshold
    input wire logic I_CS_PEAK,         // Current sense at peak limit
    input wire logic I_CS_SHORT,        // Current sense above short level
    input wire logic I_OVERLOAD,        // Overload indication
    output logic O_GATE,                // Power switch drive
    output logic O_HV_CHARGE,           // High-voltage start-up path on
    output logic O_RUN,                 // Switching allowed
    output logic O_SOFTSTART,           // Soft-start in progress
    output logic O_FAULT,               // Protection hold-off active
    output logic [3:0] O_ILIM_LEVEL     // Peak-current limit reference
);
    // Sized copies of the timing counts
    localparam logic [7:0] LEB_C = 8'(`QF_LEB_CYC);
    localparam logic [7:0] TON_C = 8'(`QF_TON_CYC);
    localparam logic [8:0] PER_C = 9'(`QF_PER_CYC);
    localparam logic [2:0] SH_C = 3'(`QF_SHORT_CYC);
    localparam logic [1:0] GOOD_C = 2'(`QF_BIN_GOOD - 1);
    localparam logic [2:0] BAD_C = 3'(`QF_BIN_BAD - 1);
    localparam logic [3:0] SS_C = 4'(`QF_SS_STEP - 1);
    localparam long_t BO_C = 25'(BO_CYC - 1);
    localparam long_t RST_C = 25'(RST_CYC - 1);
    localparam long_t FLT_C = 25'(FLT_CYC - 1);

    // Long counts must fit the 25-bit counters
    if (BO_CYC < 1 || BO_CYC > 33554432 || RST_CYC < 1 ||
        RST_CYC > 33554432 || FLT_CYC < 1 || FLT_CYC > 33554432) begin : g_chk
        $error("Delay parameter out of range");
    end

    core_t q; // Registered state
    core_t n; // Next state
    cmp_t cmp_in; // Raw comparator levels
    logic pwm; // Switching state
    logic blank; // Within turn-on blanking
    logic dm_edge; // Aux sense just dropped below threshold
    logic trip; // Protection event this cycle

    assign cmp_in = '{I_VCC_ABOVE_START, I_VCC_BELOW_RESET, I_BROWN_IN_OK,
        I_BROWN_OUT_LOW, I_DEMAG, I_CS_PEAK, I_CS_SHORT, I_OVERLOAD};

    // Next-state logic of the whole core
    always_comb begin
        n = q;
        n.sy1 = cmp_in;
        n.sy2 = q.sy1;
        n.dm_prev = q.sy2.demag;
        pwm = (q.st == S_SOFT) || (q.st == S_RUN);
        blank = q.ontmr < LEB_C;
        // Level, not edge, would retrigger while the aux ring settles
        dm_edge = q.sy2.demag && !q.dm_prev;
        trip = 1'b0;
        unique case (q.st)
            S_OFF: begin
                // Charger stays on until the supply is up
                if (q.sy2.vcc_start && !q.sy2.vcc_low) begin
                    n.st = S_QUAL;
                    n.good = 2'h0;
                    n.bad = 3'h0;
                    n.pertmr = 9'h0;
                end
            end
            S_QUAL: begin
                // Brown-in sampled once per maximum-period slot
                n.pertmr = q.pertmr + 9'h1;
                if (q.pertmr == PER_C - 9'h1) begin
                    n.pertmr = 9'h0;
                    if (q.sy2.bin_ok) begin
                        n.bad = 3'h0;
                        n.good = q.good + 2'h1;
                        if (q.good == GOOD_C) begin
                            n.st = S_SOFT;
                            n.lvl = `QF_LVL_MIN;
                            n.sscnt = 4'h0;
                            n.bo = '0;
                        end
                    end else begin
                        n.good = 2'h0;
                        n.bad = q.bad + 3'h1;
                        if (q.bad == BAD_C) begin
                            n.st = S_RSTDLY;
                            n.dly = '0;
                        end
                    end
                end
            end
            S_SOFT, S_RUN: begin
                n.pertmr = q.pertmr + 9'h1;
                if (q.gate) begin
                    n.ontmr = q.ontmr + 8'h1;
                    // Short must persist past blanking
                    if (!blank && q.sy2.cs_short) begin
                        n.shcnt = q.shcnt + 3'h1;
                        if (q.shcnt == SH_C - 3'h1) begin
                            trip = 1'b1;
                        end
                    end else begin
                        n.shcnt = 3'h0;
                    end
                    // Peak ignored while blanking; on-time cap
                    if ((!blank && q.sy2.cs_peak) ||
                        q.ontmr == TON_C - 8'h1) begin
                        n.gate = 1'b0;
                    end
                end else begin
                    n.shcnt = 3'h0;
                    if (dm_edge || q.pertmr == PER_C - 9'h1) begin
                        n.gate = 1'b1;
                        n.ontmr = 8'h0;
                        n.pertmr = 9'h0;
                        // Ramp advances in switching cycles
                        if (q.st == S_SOFT) begin
                            n.sscnt = q.sscnt + 4'h1;
                            if (q.sscnt == SS_C) begin
                                n.sscnt = 4'h0;
                                if (q.lvl == `QF_LVL_MAX) begin
                                    n.st = S_RUN;
                                end else begin
                                    n.lvl = q.lvl + 4'h1;
                                end
                            end
                        end
                    end
                end
                // Brown-out needs an unbroken low input
                if (q.sy2.bo_low) begin
                    n.bo = q.bo + 25'h1;
                    if (q.bo == BO_C) begin
                        n.st = S_RSTDLY;
                        n.dly = '0;
                    end
                end else begin
                    n.bo = '0;
                end
                if (q.sy2.overload) begin
                    trip = 1'b1;
                end
                // Protection outranks brown-out
                if (trip) begin
                    n.st = S_FAULT;
                    n.dly = '0;
                end
            end
            S_RSTDLY: begin
                n.dly = q.dly + 25'h1;
                if (q.dly == RST_C) begin
                    n.st = S_OFF;
                end
            end
            S_FAULT: begin
                n.dly = q.dly + 25'h1;
                if (q.dly == FLT_C) begin
                    n.st = S_OFF;
                end
            end
        endcase
        // Undervoltage lockout overrides every state
        if (q.st != S_OFF && q.sy2.vcc_low) begin
            n.st = S_OFF;
        end
        // Gate only ever high in a switching state
        if (n.st != S_SOFT && n.st != S_RUN) begin
            n.gate = 1'b0;
            n.shcnt = 3'h0;
        end
        n.hv = n.st == S_OFF;
        n.run = (n.st == S_SOFT) || (n.st == S_RUN);
        n.ss = n.st == S_SOFT;
        n.flt = n.st == S_FAULT;
        if (n.st == S_RUN) begin
            n.lvl = `QF_LVL_MAX;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            q <= '0;
            q.st <= S_OFF;
            q.hv <= 1'b1;
            q.lvl <= `QF_LVL_MIN;
        end else if (I_CE) begin
            q <= n;
        end
    end

    assign O_GATE = q.gate;
    assign O_HV_CHARGE = q.hv;
    assign O_RUN = q.run;
    assign O_SOFTSTART = q.ss;
    assign O_FAULT = q.flt;
    assign O_ILIM_LEVEL = q.lvl;

    property p_hv_off;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        q.st == S_OFF && q.sy2.vcc_start && !q.sy2.vcc_low
        |=> !q.hv && q.st == S_QUAL;
    endproperty
    a_hv_off: assert property (p_hv_off)
        else $error("Charger not released at start-up");

    property p_supply_undervoltage_lockout;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        q.st != S_OFF && q.sy2.vcc_low |=> q.st == S_OFF && !q.gate && q.hv;
    endproperty
    a_supply_undervoltage_lockout: assert property (p_supply_undervoltage_lockout)
        else $error("Undervoltage did not stop operation");

    property p_qual_good;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        q.st == S_SOFT && $past(q.st) == S_QUAL
        |-> $past(q.good) == 2'h2 && q.lvl == `QF_LVL_MIN;
    endproperty
    a_qual_good: assert property (p_qual_good)
        else $error("Soft-start without three good cycles");

    property p_qual_bad;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        q.st == S_RSTDLY && $past(q.st) == S_QUAL |-> $past(q.bad) == 3'h5;
    endproperty
    a_qual_bad: assert property (p_qual_bad)
        else $error("Restart without six bad cycles");

    property p_blank;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        (q.gate && q.ontmr < LEB_C) ##1 (q.st == $past(q.st)) |-> q.gate;
    endproperty
    a_blank: assert property (p_blank)
        else $error("Switch ended during blanking");

    property p_ton;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        q.gate |-> q.ontmr < TON_C;
    endproperty
    a_ton: assert property (p_ton)
        else $error("On-time exceeded");

    // Longest period ends in a forced turn-on unless the state is left
    property p_period;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        pwm && !q.gate && q.pertmr == PER_C - 9'h1 && !q.sy2.vcc_low &&
        !trip && !(q.sy2.bo_low && q.bo == BO_C)
        |=> q.gate && q.pertmr == 9'h0;
    endproperty
    a_period: assert property (p_period)
        else $error("Switching period exceeded");

    property p_peak;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        q.gate && !blank && q.sy2.cs_peak |=> !q.gate;
    endproperty
    a_peak: assert property (p_peak)
        else $error("Peak current did not end the cycle");

    property p_demag;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        pwm && !q.gate && dm_edge && !q.sy2.vcc_low && !trip &&
        !(q.sy2.bo_low && q.bo == BO_C) |=> q.gate;
    endproperty
    a_demag: assert property (p_demag)
        else $error("Demagnetization did not start a cycle");

    property p_brownout;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        pwm && q.sy2.bo_low && q.bo == BO_C && !trip && !q.sy2.vcc_low
        |=> q.st == S_RSTDLY && !q.gate;
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("Brown-out not taken");

    property p_fault_hold;
        @(posedge I_CLK) disable iff (I_SRST || !I_CE)
        q.st == S_FAULT && q.dly != FLT_C && !q.sy2.vcc_low
        |=> q.st == S_FAULT && !q.gate;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("Fault hold-off cut short");
endmodule : qr_flyback_pwm_sequencer

//--- tb/flyback_far_side.sv
// Behavioural sense comparators and switch seen from the gate drive
`timescale 1ns/1ns
module flyback_far_side (
    input wire logic clk,
    input wire logic gate,
    input wire logic run,
    input wire logic [1:0] mode,     // 0 normal, 1 no peak, 2 stuck peak
    input wire logic demag_en,       // Low: winding never demagnetises
    input wire logic [7:0] on_dly,   // Cycles from turn-on to peak current
    input wire logic [7:0] off_dly,  // Cycles from turn-off to demag
    output logic demag,
    output logic cs_peak
);
    logic [8:0] cnt; // Cycles since the gate last changed
    logic gate_q; // Gate as seen one edge ago
    initial begin
        cnt = 9'h0;
        gate_q = 1'b0;
        demag = 1'b0;
        cs_peak = 1'b0;
    end
    // Ramp and ring timing; demag only while switching is allowed, so
    // every switching phase opens on a fresh falling aux voltage
    always @(posedge clk) begin
        gate_q <= gate;
        cnt <= (gate != gate_q) ? 9'h0 : cnt + 9'h1;
        cs_peak <= (mode == 2'h2) ||
            (mode == 2'h0 && gate && cnt >= {1'b0, on_dly});
        demag <= demag_en && run && !gate && cnt >= {1'b0, off_dly};
    end
endmodule : flyback_far_side

//--- tb/tb_top.sv
// Self-checking bench of the flyback sequencer with far-side model
`timescale 1ns/1ns
`include "qr_flyback_defines.svh"
module tb_top;
    localparam int BO = 20; // Shortened brown-out persistence
    localparam int RST = 10; // Shortened reset delay
    localparam int FLT = 30; // Shortened protection hold-off
    localparam int PER = `QF_PER_CYC;
    localparam int TON = `QF_TON_CYC;
    localparam int TURN_ON_BLANKING = `QF_LEB_CYC;
    localparam int SHRT = `QF_SHORT_CYC;
    localparam int LIMIT = 60000; // Whole run is about 17000 cycles
    logic clk, srst, ce, vcc_start, vcc_low, bin_ok, bo_low;
    logic cs_short, overload, gate, hv, run, ss, fault, demag, cs_peak;
    logic [3:0] ilim; // Peak-limit code from the core
    logic [1:0] mode; // Far-side behaviour select
    logic dm_en, g_prev;
    logic [7:0] on_dly, off_dly;
    logic [31:0] seed; // Random source for pulse timing
    int failures, total_checks, cycles, n, on_n, per_n, dm_age, cs_age;
    int ss_n; // Turn-ons seen in the current soft-start phase

    qr_flyback_pwm_sequencer #(.BO_CYC(BO), .RST_CYC(RST), .FLT_CYC(FLT))
        i_dut (.I_CLK(clk), .I_SRST(srst), .I_CE(ce),
        .I_VCC_ABOVE_START(vcc_start), .I_VCC_BELOW_RESET(vcc_low),
        .I_BROWN_IN_OK(bin_ok), .I_BROWN_OUT_LOW(bo_low),
        .I_DEMAG(demag), .I_CS_PEAK(cs_peak), .I_CS_SHORT(cs_short),
        .I_OVERLOAD(overload), .O_GATE(gate), .O_HV_CHARGE(hv),
        .O_RUN(run), .O_SOFTSTART(ss), .O_FAULT(fault),
        .O_ILIM_LEVEL(ilim));
    flyback_far_side i_far (.clk(clk), .gate(gate), .run(run), .mode(mode),
        .demag_en(dm_en), .on_dly(on_dly), .off_dly(off_dly),
        .demag(demag), .cs_peak(cs_peak));

    // Half period of 50 ns
    always #50 clk = ~clk;

    // Fibonacci-style shift register, fixed start for repeatable runs
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic outv(input int s);
        case (s)
            0: return gate;
            1: return hv;
            2: return run;
            3: return ss;
            default: return fault;
        endcase
    endfunction : outv

    task automatic chk_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_lvl(input string nm, input logic [3:0] e,
        input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_lvl

    task automatic chk_rng(input string nm, input int v, input int lo,
        input int hi);
        total_checks++;
        if (v < lo || v > hi) begin
            failures++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask : chk_rng

    // Bounded wait for an output level, counted in falling edges
    task automatic wt(input int s, input logic v, input int lim,
        output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (outv(s) !== v && k < lim);
        chk_bit("wait_level", v, outv(s));
    endtask : wt

    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            wrap_up();
        end
    end

    // Pulse watch; also draws fresh far-side timing at each turn-on
    always @(negedge clk) begin
        if (!ss) ss_n = 0;
        if (gate && !g_prev) begin
            if (run && !dm_en) chk_rng("period", per_n, PER - 1, PER + 2);
            // Limit code climbs one step per block of turn-ons
            if (ss) begin
                ss_n++;
                chk_lvl("ss_lvl", 4'(1 + ss_n / `QF_SS_STEP), ilim);
            end
            per_n = 1;
            on_n = 1;
            seed = lfsr(seed);
            on_dly = {2'h0, seed[5:0]} + 8'h4;
            off_dly = {3'h0, seed[12:8]} + 8'h2;
        end else begin
            per_n++;
            if (gate) on_n++;
        end
        if (!gate && g_prev && mode == 2'h1 && !cs_short) begin
            chk_rng("on_max", on_n, TON - 1, TON + 1);
        end
        if (!gate && g_prev && mode == 2'h2) begin
            chk_rng("blank", on_n, TURN_ON_BLANKING, TURN_ON_BLANKING + 3);
        end
        dm_age = demag ? dm_age + 1 : 0;
        cs_age = (cs_peak && mode == 2'h0) ? cs_age + 1 : 0;
        if (dm_age == 4 && run) chk_bit("demag_on", 1'b1, gate);
        if (cs_age == 4 && run) chk_bit("peak_off", 1'b0, gate);
        g_prev = gate;
    end

    // Main sequence
    initial begin
        {clk, vcc_start, vcc_low, bin_ok, bo_low, cs_short} = 6'h0;
        {overload, g_prev} = 2'h0;
        {srst, ce, dm_en} = 3'h7;
        mode = 2'h0;
        on_dly = 8'h8;
        off_dly = 8'h4;
        seed = 32'h1ec4;
        {failures, total_checks, cycles, on_n, per_n, dm_age, cs_age} = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk_bit("gate_rst", 1'b0, gate);
        chk_bit("run_rst", 1'b0, run);
        chk_bit("ss_fault_rst", 1'b0, ss | fault);
        chk_lvl("ilim_rst", 4'h1, ilim);
        repeat (20) @(negedge clk);
        chk_bit("hv_before_start", 1'b1, hv);
        @(posedge clk) vcc_start <= 1'b1;
        wt(1, 1'b0, 8, n);
        chk_rng("hv_off", n, 3, 5);
        wt(1, 1'b1, 3000, n);
        chk_rng("bad_qual", n, 6 * PER + RST - 2, 6 * PER + RST + 6);
        wt(1, 1'b0, 8, n);
        chk_rng("requal", n, 1, 3);
        @(posedge clk) bin_ok <= 1'b1;
        wt(3, 1'b1, 1400, n);
        chk_rng("qual_ok", n, 3 * PER - 10, 3 * PER + 6);
        chk_bit("run_in_soft", 1'b1, run);
        chk_lvl("ilim_soft", 4'h1, ilim);
        wt(3, 1'b0, 20000, n);
        chk_lvl("ilim_full", 4'hf, ilim);
        wt(0, 1'b0, 500, n);
        @(posedge clk) mode <= 2'h2;
        repeat (300) @(negedge clk);
        // Change over with the switch off, so that a stuck-peak pulse
        // is never taken for an on-time cap
        wt(0, 1'b0, 500, n);
        @(posedge clk) mode <= 2'h1;
        repeat (700) @(negedge clk);
        wt(0, 1'b1, 500, n);
        @(posedge clk) {mode, dm_en} <= 3'h0;
        repeat (1300) @(negedge clk);
        @(posedge clk) {dm_en, bo_low} <= 2'h3;
        wt(2, 1'b0, 40, n);
        chk_rng("brown_out", n, BO + 2, BO + 6);
        chk_bit("bo_gate", 1'b0, gate);
        wt(1, 1'b1, 30, n);
        chk_rng("bo_delay", n, RST, RST + 4);
        @(posedge clk) bo_low <= 1'b0;
        wt(1, 1'b0, 8, n);
        wt(3, 1'b1, 1400, n);
        wt(0, 1'b0, 500, n);
        @(posedge clk) {mode, cs_short} <= 3'h3;
        wt(4, 1'b1, 500, n);
        chk_rng("short_qual", on_n, SHRT, TURN_ON_BLANKING + SHRT + 3);
        chk_bit("fault_gate", 1'b0, gate);
        wt(4, 1'b0, 60, n);
        chk_rng("hold_off", n, FLT, FLT + 3);
        chk_bit("fault_end_hv", 1'b1, hv);
        @(posedge clk) {mode, cs_short} <= 3'h0;
        wt(3, 1'b1, 1500, n);
        @(posedge clk) vcc_low <= 1'b1;
        wt(2, 1'b0, 8, n);
        chk_rng("supply_undervoltage_lockout", n, 3, 5);
        repeat (20) @(negedge clk);
        chk_bit("supply_undervoltage_lockout_hold", 1'b1, hv & !gate);
        @(posedge clk) vcc_low <= 1'b0;
        wt(3, 1'b1, 1500, n);
        @(posedge clk) overload <= 1'b1;
        wt(4, 1'b1, 8, n);
        chk_rng("overload", n, 3, 5);
        // Enable low must freeze the hold-off count past its normal end
        @(posedge clk) {overload, ce} <= 2'h0;
        repeat (50) @(negedge clk);
        chk_bit("ce_freeze", 1'b1, fault);
        @(posedge clk) ce <= 1'b1;
        wt(4, 1'b0, 60, n);
        chk_rng("ce_resume", n, FLT - 2, FLT + 2);
        wrap_up();
    end
endmodule : tb_top
